// ---- beau_top.sv ----
// access logic between the core's i/o space and a 512-byte nonvolatile store
// assumes single-cycle i/o strobes from the core on clk_sys, same domain
`include "beau_regs.svh"
`default_nettype none
module beau_top
   import beau_pkg::*;
#(
   parameter int WRITE_CYCLES = `BEAU_WRITE_CYCLES  // self-timed write length
)
(
   input  wire logic        clk_sys,    // system clock, 250 mhz
   input  wire logic        rst,        // async reset, active high
   input  wire logic [5:0]  io_addr,    // i/o register offset
   input  wire logic        io_wr,      // i/o write strobe
   input  wire logic        io_rd,      // i/o read strobe
   input  wire logic [7:0]  io_wdata,   // i/o write data
   output var  logic [7:0]  io_rdata,   // i/o read data, registered
   output var  logic        cpu_stall,  // halt the core
   output var  logic        nv_store_ready_interrupt, // ready request
   output var  logic [15:0] nv_ready_vector           // vector address
);
   // ****************************************
   // state
   // ****************************************
   logic [7:0]  addr_low_reg,  addr_low_next;   // address bits 7..0
   logic        addr_high_reg, addr_high_next;  // address bit 8
   logic [7:0]  data_reg,      data_next;       // data register
   logic        rdy_ie_reg,    rdy_ie_next;     // ready interrupt enable
   logic [2:0]  master_reg,    master_next;     // protected window count
   logic [2:0]  stall_reg,     stall_next;      // core stall count
   logic        rd_pend_reg,   rd_pend_next;    // read data arriving
   logic [15:0] wcnt_reg,      wcnt_next;       // write time left
   beau_addr_t  waddr_reg,     waddr_next;      // latched write address
   logic [7:0]  wdata_reg,     wdata_next;      // latched write byte
   beau_state_t state_reg,     state_next;      // write engine
   logic [7:0]  rdata_next;                     // read mux
   logic        ctrl_wr;                        // control write
   logic        rd_go;                          // accepted read
   logic        wr_go;                          // accepted write
   logic        mem_we;                         // commit byte
   logic [7:0]  mem_dout;                       // array read data
   beau_addr_t  mem_addr;                       // array address

   // ****************************************
   // access decode
   // ****************************************
   // a new access while writing is dropped, the byte in flight must finish
   always_comb
   begin
      ctrl_wr = io_wr && (io_addr == `BEAU_OFS_CTRL);
      rd_go   = ctrl_wr && io_wdata[`BEAU_CTRL_READ]
                && (state_reg == BEAU_IDLE);
      wr_go   = ctrl_wr && io_wdata[`BEAU_CTRL_WRITE] && !rd_go
                && (master_reg != 3'h0) && (state_reg == BEAU_IDLE);
      mem_we  = (state_reg == BEAU_WRITING) && (wcnt_reg == 16'h0001);
      mem_addr = mem_we ? waddr_reg : {addr_high_reg, addr_low_reg};
   end

   // ****************************************
   // register file next values
   // ****************************************
   always_comb
   begin
      addr_low_next  = addr_low_reg;
      addr_high_next = addr_high_reg;
      data_next      = data_reg;
      rdy_ie_next    = rdy_ie_reg;
      master_next    = (master_reg != 3'h0) ? master_reg - 3'h1 : 3'h0;
      rd_pend_next   = rd_go;
      if (io_wr)
      begin
         case (io_addr)
            `BEAU_OFS_ADDR_LOW:  addr_low_next  = io_wdata;
            `BEAU_OFS_ADDR_HIGH: addr_high_next = io_wdata[0];
            `BEAU_OFS_DATA:      data_next      = io_wdata;
            `BEAU_OFS_CTRL:
            begin
               rdy_ie_next = io_wdata[`BEAU_CTRL_RDY_IE];
               // master alone opens the window; with write it is consumed
               if (io_wdata[`BEAU_CTRL_MASTER] && !io_wdata[`BEAU_CTRL_WRITE])
               begin
                  master_next = `BEAU_MASTER_WINDOW;
               end
               else if (wr_go)
               begin
                  master_next = 3'h0;
               end
            end
            default: ;                                             // others ignored
         endcase
      end
      // fresh array byte wins over a write to the data register
      if (rd_pend_reg)
      begin
         data_next = mem_dout;
      end
   end

   // ****************************************
   // write engine and stall next values
   // ****************************************
   always_comb
   begin
      state_next = state_reg;
      wcnt_next  = wcnt_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      stall_next = (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
      if (rd_go)
      begin
         stall_next = `BEAU_READ_STALL;
      end
      else if (wr_go)
      begin
         stall_next = `BEAU_WRITE_STALL;
      end
      case (state_reg)
         BEAU_IDLE:
         begin
            if (wr_go)
            begin
               state_next = BEAU_WRITING;
               wcnt_next  = 16'(WRITE_CYCLES);
               waddr_next = {addr_high_reg, addr_low_reg};
               wdata_next = data_reg;
            end
         end
         BEAU_WRITING:
         begin
            wcnt_next = wcnt_reg - 16'h0001;
            if (wcnt_reg == 16'h0001)
            begin
               state_next = BEAU_IDLE;
            end
         end
         default: state_next = BEAU_IDLE;
      endcase
   end

   // ****************************************
   // read data mux
   // ****************************************
   always_comb
   begin
      rdata_next = 8'h00;
      case (io_addr)
         `BEAU_OFS_ADDR_LOW:  rdata_next = addr_low_reg;
         `BEAU_OFS_ADDR_HIGH: rdata_next = {7'h00, addr_high_reg};
         `BEAU_OFS_DATA:      rdata_next = data_reg;
         `BEAU_OFS_CTRL:
         begin
            rdata_next[`BEAU_CTRL_WRITE]  = (state_reg == BEAU_WRITING);
            rdata_next[`BEAU_CTRL_MASTER] = (master_reg != 3'h0);
            rdata_next[`BEAU_CTRL_RDY_IE] = rdy_ie_reg;
         end
         default: rdata_next = 8'h00;                              // unmapped reads zero
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   // address bits have no reset: software must load them before use
   always_ff @(posedge clk_sys)
   begin
      addr_low_reg  <= addr_low_next;
      addr_high_reg <= addr_high_next;
      waddr_reg     <= waddr_next;
      wdata_reg     <= wdata_next;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         data_reg    <= 8'h00;
         rdy_ie_reg  <= 1'b0;
         master_reg  <= 3'h0;
         stall_reg   <= 3'h0;
         rd_pend_reg <= 1'b0;
         wcnt_reg    <= 16'h0000;
         state_reg   <= BEAU_IDLE;
         io_rdata    <= 8'h00;
      end
      else
      begin
         data_reg    <= data_next;
         rdy_ie_reg  <= rdy_ie_next;
         master_reg  <= master_next;
         stall_reg   <= stall_next;
         rd_pend_reg <= rd_pend_next;
         wcnt_reg    <= wcnt_next;
         state_reg   <= state_next;
         io_rdata    <= io_rd ? rdata_next : 8'h00;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_comb
   begin
      cpu_stall                = (stall_reg != 3'h0);
      nv_store_ready_interrupt = rdy_ie_reg && (state_reg == BEAU_IDLE);
      nv_ready_vector          = `BEAU_READY_VECTOR;
   end

   // storage array, 512 bytes
   beau_mem u_mem
   (
      .clk_sys (clk_sys),
      .we      (mem_we),
      .re      (rd_go),
      .addr    (mem_addr),
      .din     (wdata_reg),
      .dout    (mem_dout)
   );

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_read_stall_len: assert property (rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall not four cycles");
   a_write_stall_len: assert property (wr_go |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall not two cycles");
   a_write_unlock: assert property ($rose(state_reg == BEAU_WRITING) |-> $past(master_reg != 3'h0))
      else $error("write started without protected sequence");
   a_busy_hold: assert property ((state_reg == BEAU_WRITING) && (wcnt_reg > 16'h0001)
                                 |=> state_reg == BEAU_WRITING)
      else $error("busy dropped before write done");
   a_ready_irq: assert property (mem_we && rdy_ie_reg && !ctrl_wr |=> nv_store_ready_interrupt)
      else $error("ready interrupt missing after write");
   a_high_zero: assert property (io_rd && io_addr == `BEAU_OFS_ADDR_HIGH |=> io_rdata[7:1] == 7'h00)
      else $error("high address upper bits not zero");
   a_addr_back: assert property (io_wr && io_addr == `BEAU_OFS_ADDR_LOW ##1
                                 io_rd && !io_wr && io_addr == `BEAU_OFS_ADDR_LOW
                                 |=> io_rdata == $past(io_wdata, 2))
      else $error("low address readback mismatch");
   a_commit_once: assert property (mem_we |=> !mem_we && state_reg == BEAU_IDLE)
      else $error("byte commit not single");

   c_read:    cover property (rd_go ##5 rd_pend_reg == 1'b0);
   c_write:   cover property (wr_go);
   c_irq:     cover property ($rose(nv_store_ready_interrupt));
   c_refused: cover property (ctrl_wr && io_wdata[`BEAU_CTRL_WRITE] && master_reg == 3'h0);
endmodule
`default_nettype wire

// ---- beau_regs.svh ----
// register offsets, field positions, reset values and timing counts of the
// nonvolatile byte store access unit; included by the top, the core model and the bench
`ifndef BEAU_REGS_SVH
`define BEAU_REGS_SVH

// ****************************************
// i/o space offsets
// ****************************************
`define BEAU_OFS_CTRL        6'h1f
`define BEAU_OFS_DATA        6'h20
`define BEAU_OFS_ADDR_LOW    6'h21
`define BEAU_OFS_ADDR_HIGH   6'h22

// ****************************************
// control register fields
// ****************************************
`define BEAU_CTRL_READ       0
`define BEAU_CTRL_WRITE      1
`define BEAU_CTRL_MASTER     2
`define BEAU_CTRL_RDY_IE     3
`define BEAU_CTRL_RESET      8'h00

// ****************************************
// store geometry and timing
// ****************************************
`define BEAU_ADDR_BITS       9
`define BEAU_DEPTH           512
`define BEAU_READ_STALL      3'h4
`define BEAU_WRITE_STALL     3'h2
`define BEAU_MASTER_WINDOW   3'h4
`define BEAU_WRITE_CYCLES    1000
`define BEAU_READY_VECTOR    16'h002c

`endif

// ---- beau_pkg.sv ----
// types shared by the nonvolatile byte store access unit
// assumes beau_regs.svh sits in the include path
`default_nettype none
package beau_pkg;
   // write engine: idle or busy with a self-timed byte write
   typedef enum logic {BEAU_IDLE, BEAU_WRITING} beau_state_t;
   typedef logic [8:0] beau_addr_t;
endpackage
`default_nettype wire

// ---- beau_mem.sv ----
// byte-wide storage array of the nonvolatile store
// assumes one clock; read data come out of a register one edge after re
`default_nettype none
module beau_mem
   import beau_pkg::*;
(
   input  wire logic       clk_sys, // system clock
   input  wire logic       we,      // write one byte
   input  wire logic       re,      // read one byte
   input  wire beau_addr_t addr,    // byte address
   input  wire logic [7:0] din,     // write data
   output var  logic [7:0] dout     // registered read data
);
   // ****************************************
   // storage
   // ****************************************
   logic [7:0] mem_array [0:511];   // no reset: contents are nonvolatile

   // one byte per access, never wider
   always_ff @(posedge clk_sys)
   begin
      if (we)
      begin
         mem_array[addr] <= din;
      end
      if (re)
      begin
         dout <= mem_array[addr];
      end
   end
endmodule
`default_nettype wire

// ---- beau_core_model.sv ----
// processor core model issuing i/o accesses to the store access unit
// assumes beau_top on clk_sys; strobes move at the falling edge only
`include "beau_regs.svh"
`default_nettype none
module beau_core_model
(
   input  wire logic       clk_sys,  // system clock
   input  wire logic [7:0] io_rdata, // read data from the unit
   output var  logic [5:0] io_addr,  // register offset
   output var  logic       io_wr,    // write strobe
   output var  logic       io_rd,    // read strobe
   output var  logic [7:0] io_wdata  // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // bus cycles
   // ****************************************
   initial
   begin
      io_addr = 6'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // one-cycle write; afterwards the bus shows inverted junk, not the old value
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk_sys);
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   // one-cycle read; data is taken in the cycle after the strobe edge
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk_sys);
      io_rd = 1'b0;
      d = io_rdata;
      io_addr = ~a;
   endtask
   // write, then read back the same offset at the very next edge, no idle gap
   task automatic wr_rd(input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_sys);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk_sys);
      io_wr = 1'b0;
      io_rd = 1'b1;
      io_wdata = ~d;
      @(negedge clk_sys);
      io_rd = 1'b0;
      q = io_rdata;
      io_addr = ~a;
   endtask
   // poll busy until clear before any new access; bounded so a hang shows
   task automatic wait_ready(output logic ok);
      logic [7:0] v;
      ok = 1'b0;
      repeat (64)
      begin
         rd(`BEAU_OFS_CTRL, v);
         if (v[1] === 1'b0)
         begin
            ok = 1'b1;
            break;
         end
      end
   endtask
   // master enable, then the write command after one idle cycle
   task automatic start_write(input logic [7:0] ie);
      wr(`BEAU_OFS_CTRL, 8'h04 | ie);
      wr(`BEAU_OFS_CTRL, 8'h02 | ie);
   endtask
endmodule
`default_nettype wire

// ---- byte_eeprom_access_unit_bench.sv ----
// self-checking bench of the store access unit with a core model
// assumes the design and beau_core_model are compiled before this file
`include "beau_regs.svh"
`default_nettype none
module byte_eeprom_access_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WCYC = 8; // short write time keeps the run brief
   logic        clk_sys;  // system clock
   logic        rst;      // reset
   logic [5:0]  io_addr;  // offset
   logic        io_wr;    // write strobe
   logic        io_rd;    // read strobe
   logic [7:0]  io_wdata; // write data
   logic [7:0]  io_rdata; // read data
   logic        cpu_stall; // core halt
   logic        irq;      // ready request
   logic [15:0] vec;      // vector
   logic [7:0]  v;        // read value
   logic        ok;       // poll result
   int bad_count = 0;
   int comparisons = 0;
   int stall_cycles = 0;
   int cycles = 0;
   // ****************************************
   // clock, instances, watchdog
   // ****************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   beau_top #(.WRITE_CYCLES(WCYC)) dut_u (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .cpu_stall(cpu_stall), .nv_store_ready_interrupt(irq), .nv_ready_vector(vec));
   beau_core_model core_u (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
   // count stalled cycles; a runaway run is cut off here
   always @(negedge clk_sys)
   begin
      cycles++;
      if (cpu_stall === 1'b1)
         stall_cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (bad_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      check("rdata", {8'h00, io_rdata}, 16'h0000);
      check("stall", {15'h0, cpu_stall}, 16'h0000);
      check("irq", {15'h0, irq}, 16'h0000);
      check("vector", vec, 16'h002c);
      core_u.wr(`BEAU_OFS_ADDR_HIGH, 8'hff);
      core_u.rd(`BEAU_OFS_ADDR_HIGH, v);
      check("addr_high", {8'h00, v}, 16'h0001);
      core_u.wr(`BEAU_OFS_ADDR_LOW, 8'ha5);
      core_u.rd(`BEAU_OFS_ADDR_LOW, v);
      check("addr_low", {8'h00, v}, 16'h00a5);
      // back-to-back write and read of the same register
      core_u.wr_rd(`BEAU_OFS_ADDR_LOW, 8'h3c, v);
      check("addr_back", {8'h00, v}, 16'h003c);
      // an offset outside the map reads zero
      core_u.rd(6'h00, v);
      check("unmapped", {8'h00, v}, 16'h0000);
   endtask
   // a write command with the window closed or expired must not start
   task automatic t_refused();
      core_u.wr(`BEAU_OFS_CTRL, 8'h02);
      core_u.rd(`BEAU_OFS_CTRL, v);
      check("busy_nomaster", {15'h0, v[1]}, 16'h0000);
      core_u.wr(`BEAU_OFS_CTRL, 8'h04);
      repeat (6) @(negedge clk_sys);
      core_u.wr(`BEAU_OFS_CTRL, 8'h02);
      core_u.rd(`BEAU_OFS_CTRL, v);
      check("busy_expired", {15'h0, v[1]}, 16'h0000);
   endtask
   task automatic t_write(input logic [8:0] a, input logic [7:0] d);
      core_u.wr(`BEAU_OFS_ADDR_LOW, a[7:0]);
      core_u.wr(`BEAU_OFS_ADDR_HIGH, {7'h00, a[8]});
      core_u.wr(`BEAU_OFS_DATA, d);
      #1 stall_cycles = 0;
      core_u.start_write(8'h08);
      core_u.rd(`BEAU_OFS_CTRL, v);
      check("busy", {15'h0, v[1]}, 16'h0001);
      check("irq_busy", {15'h0, irq}, 16'h0000);
      check("wr_stall", 16'(stall_cycles), 16'h0002);
      // a read command while the write runs must be dropped: no stall
      #1 stall_cycles = 0;
      core_u.wr(`BEAU_OFS_CTRL, 8'h09);
      repeat (2) @(negedge clk_sys);
      check("busy_rd_stall", 16'(stall_cycles), 16'h0000);
      core_u.wait_ready(ok);
      check("ready", {15'h0, ok}, 16'h0001);
      @(negedge clk_sys);
      check("irq_ready", {15'h0, irq}, 16'h0001);
   endtask
   task automatic t_read(input logic [8:0] a, input logic [7:0] d);
      core_u.wr(`BEAU_OFS_ADDR_LOW, a[7:0]);
      core_u.wr(`BEAU_OFS_ADDR_HIGH, {7'h00, a[8]});
      // window open and read plus write together: the read must win
      core_u.wr(`BEAU_OFS_CTRL, 8'h0c);
      #1 stall_cycles = 0;
      core_u.wr(`BEAU_OFS_CTRL, 8'h0b);
      repeat (6) @(negedge clk_sys);
      check("rd_stall", 16'(stall_cycles), 16'h0004);
      core_u.rd(`BEAU_OFS_CTRL, v);
      check("rd_wins", {15'h0, v[1]}, 16'h0000);
      check("irq_idle", {15'h0, irq}, 16'h0001);
      core_u.rd(`BEAU_OFS_DATA, v);
      check("rd_byte", {8'h00, v}, {8'h00, d});
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
      t_refused();
      t_write(9'h1ff, 8'h5a);
      t_write(9'h0ff, 8'hc3);
      t_read(9'h1ff, 8'h5a);
      t_read(9'h0ff, 8'hc3);
      core_u.wr(`BEAU_OFS_CTRL, 8'h00);
      @(negedge clk_sys);
      check("irq_masked", {15'h0, irq}, 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
